// ===== gib_chk_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module gib_chk
    import gib_pkg::*;
(
    input wire logic              sys_clk_in,
    input wire logic              reset_n_in,
    input wire logic [ADDR_W-1:0] s_axi_awaddr_in,
    input wire logic              s_axi_awvalid_in,
    input wire logic              s_axi_awready_out,
    input wire logic [1:0]        s_axi_bresp_out,
    input wire logic              s_axi_bvalid_out,
    input wire logic              s_axi_bready_in,
    input wire logic [ADDR_W-1:0] s_axi_araddr_in,
    input wire logic              s_axi_arvalid_in,
    input wire logic              s_axi_arready_out,
    input wire logic [31:0]       s_axi_rdata_out,
    input wire logic [1:0]        s_axi_rresp_out,
    input wire logic              s_axi_rvalid_out,
    input wire logic              s_axi_rready_in,
    input wire logic              busy_flag_out
);
    logic [ADDR_W-1:0] aw_q;
    logic              ar_go;
    assign ar_go = s_axi_arvalid_in && s_axi_arready_out && !s_axi_rvalid_out;
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in)
            aw_q <= '0;
        else if (s_axi_awvalid_in && s_axi_awready_out)
            aw_q <= s_axi_awaddr_in;
    end
    default clocking dcb @(posedge sys_clk_in); endclocking
    default disable iff (!reset_n_in);
    a_bresp_hold: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out
        && $stable(s_axi_bresp_out)) else $error("write answer dropped");
    a_rdata_hold: assert property (s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out
        && $stable(s_axi_rdata_out)) else $error("read answer dropped");
    a_read_answer: assert property (ar_go |=> s_axi_rvalid_out) else $error("read not answered");
    a_bad_read: assert property (ar_go && s_axi_araddr_in > OFF_DISP_SEL |=>
        s_axi_rresp_out == RESP_SLVERR && s_axi_rdata_out == 32'h0) else $error("unmapped read");
    a_bad_write: assert property ($rose(s_axi_bvalid_out) && aw_q > OFF_DISP_SEL |->
        s_axi_bresp_out == RESP_SLVERR) else $error("unmapped write");
    a_busy_cause: assert property ($rose(busy_flag_out) |-> s_axi_bvalid_out || s_axi_rvalid_out)
        else $error("busy without transfer");
    a_busy_ends: assert property ($rose(busy_flag_out) |-> ##[1:20] !busy_flag_out)
        else $error("busy stuck");
    a_busy_refuse: assert property ($rose(s_axi_bvalid_out) && $past(busy_flag_out, 2) &&
        $past(busy_flag_out) && (aw_q == OFF_CMD || aw_q == OFF_DATA) |->
        s_axi_bresp_out == RESP_SLVERR) else $error("write taken while busy");
    c_busy: cover property ($rose(busy_flag_out));
    c_refused: cover property ($rose(s_axi_bvalid_out) && s_axi_bresp_out == RESP_SLVERR);
    c_read: cover property (ar_go);
endmodule : gib_chk
bind gib_top gib_chk u_chk (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
    .s_axi_awaddr_in(s_axi_awaddr_in), .s_axi_awvalid_in(s_axi_awvalid_in), .s_axi_awready_out(s_axi_awready_out),
    .s_axi_bresp_out(s_axi_bresp_out), .s_axi_bvalid_out(s_axi_bvalid_out), .s_axi_bready_in(s_axi_bready_in),
    .s_axi_araddr_in(s_axi_araddr_in), .s_axi_arvalid_in(s_axi_arvalid_in), .s_axi_arready_out(s_axi_arready_out),
    .s_axi_rdata_out(s_axi_rdata_out), .s_axi_rresp_out(s_axi_rresp_out), .s_axi_rvalid_out(s_axi_rvalid_out),
    .s_axi_rready_in(s_axi_rready_in), .busy_flag_out(busy_flag_out));
`default_nettype wire

// ===== gib_host.sv
`timescale 1ns/1ps
`default_nettype none
module gib_host
    import gib_pkg::*;
(
    input  wire logic        clk_in,
    output logic [7:0]       awaddr_out,
    output logic             awvalid_out,
    input  wire logic        awready_in,
    output logic [31:0]      wdata_out,
    output logic             wvalid_out,
    input  wire logic        wready_in,
    input  wire logic [1:0]  bresp_in,
    input  wire logic        bvalid_in,
    output logic             bready_out,
    output logic [7:0]       araddr_out,
    output logic             arvalid_out,
    input  wire logic        arready_in,
    input  wire logic [31:0] rdata_in,
    input  wire logic [1:0]  rresp_in,
    input  wire logic        rvalid_in,
    output logic             rready_out
);
    initial {awaddr_out, awvalid_out, wdata_out, wvalid_out, bready_out, araddr_out, arvalid_out, rready_out} = '0;
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge clk_in);
        n = 0;
        awaddr_out  <= a;
        wdata_out   <= d;
        awvalid_out <= 1'b1;
        wvalid_out  <= 1'b1;
        bready_out  <= 1'b1;
        do begin
            @(posedge clk_in);
            if (awready_in) awvalid_out <= 1'b0;
            if (wready_in) wvalid_out <= 1'b0;
            n++;
        end while (!bvalid_in && n < 200);
        bready_out <= 1'b0;
        r = bresp_in;
        if (n >= 200) tb.hang();
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge clk_in);
        n = 0;
        araddr_out  <= a;
        arvalid_out <= 1'b1;
        rready_out  <= 1'b1;
        do begin
            @(posedge clk_in);
            if (arready_in) arvalid_out <= 1'b0;
            n++;
        end while (!rvalid_in && n < 200);
        rready_out <= 1'b0;
        d = rdata_in;
        r = rresp_in;
        if (n >= 200) tb.hang();
    endtask : rd
    // poll busy by instruction reads, then a spare cycle before the next strobe
    task automatic wait_idle();
        logic [31:0] d;
        logic [1:0]  r;
        int          n;
        n = 0;
        do begin
            rd(OFF_CMD, d, r);
            n++;
        end while (d[7] !== 1'b0 && n < 50);
        @(posedge clk_in);
        if (d[7] !== 1'b0) tb.hang();
    endtask : wait_idle
endmodule : gib_host
`default_nettype wire

// ===== gib_pkg.sv
package gib_pkg;
    // ------------------------------------------------------------
    // bus
    // ------------------------------------------------------------
    localparam int          ADDR_W        = 8;
    localparam logic [7:0]  OFF_CTRL      = 8'h00;
    localparam logic [7:0]  OFF_CMD       = 8'h04;
    localparam logic [7:0]  OFF_DATA      = 8'h08;
    localparam logic [7:0]  OFF_STATUS    = 8'h0C;
    localparam logic [7:0]  OFF_ICON_ROW  = 8'h10;
    localparam logic [7:0]  OFF_GLYPH_ROW = 8'h14;
    localparam logic [7:0]  OFF_DISP_SEL  = 8'h18;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;
    // ------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------
    localparam int CTRL_WIDE  = 0;
    localparam int CTRL_BLINK = 1;
    localparam int CTRL_LINES = 2;
    localparam int CTRL_IS    = 4;
    localparam int CTRL_INC   = 5;
    localparam int CTRL_ICONS = 6;
    localparam logic [1:0] LINES_ONE = 2'h0;
    // ------------------------------------------------------------
    // memory layout
    // ------------------------------------------------------------
    localparam int GLYPH_WORDS = 64;
    localparam int ICON_WORDS  = 16;
    localparam int BLINK_HI    = 7;
    localparam int BLINK_LO    = 6;
    localparam int PAT5_TOP    = 4;
    localparam int PAT6_TOP    = 5;
    localparam logic [5:0] PAT5_MASK  = 6'h1F;
    localparam logic [5:0] PAT6_MASK  = 6'h3F;
    localparam logic [5:0] COM_ICON   = 6'h00;
    localparam logic [5:0] COM_POS_1L = 6'h11;
    localparam logic [5:0] COM_POS_24 = 6'h21;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_HZ        = 10_000_000;
    localparam int BLINK_HALF_MS = 500;
    localparam int BLINK_HALF_CYC = CLK_HZ / 1000 * BLINK_HALF_MS;
    localparam int EXEC_CYC      = 4;
    localparam logic [7:0] CMD_SET_ADDR_GLYPH = 8'h40;
    localparam logic [7:0] CMD_SET_ADDR_ICON  = 8'h80;
    typedef enum logic [1:0] {GIB_IDLE, GIB_EXEC} gib_state_t;
endpackage : gib_pkg

// ===== gib_top.sv
// Our own choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module gib_top
    import gib_pkg::*;
#(
    parameter int BLINK_HALF = BLINK_HALF_CYC
) (
    input  wire logic              sys_clk_in,
    input  wire logic              reset_n_in,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr_in,
    input  wire logic              s_axi_awvalid_in,
    output logic                   s_axi_awready_out,
    input  wire logic [31:0]       s_axi_wdata_in,
    input  wire logic [3:0]        s_axi_wstrb_in,
    input  wire logic              s_axi_wvalid_in,
    output logic                   s_axi_wready_out,
    output logic [1:0]             s_axi_bresp_out,
    output logic                   s_axi_bvalid_out,
    input  wire logic              s_axi_bready_in,
    input  wire logic [ADDR_W-1:0] s_axi_araddr_in,
    input  wire logic              s_axi_arvalid_in,
    output logic                   s_axi_arready_out,
    output logic [31:0]            s_axi_rdata_out,
    output logic [1:0]             s_axi_rresp_out,
    output logic                   s_axi_rvalid_out,
    input  wire logic              s_axi_rready_in,
    output logic [5:0]             segment_out,
    output logic                   icon_active_out,
    output logic                   busy_flag_out
);
    // ------------------------------------------------------------
    // storage and state
    // ------------------------------------------------------------
    logic [7:0]  user_glyph_ram [GLYPH_WORDS];
    logic [7:0]  icon_ram [ICON_WORDS];
    logic [7:0]  ctrl;
    logic [7:0]  instruction_latch;
    logic [7:0]  data_latch;
    logic        is_data;
    logic        pend;
    logic [6:0]  addr_ctr;
    logic        target_icon;
    logic [7:0]  read_buf;
    logic [3:0]  icon_row;
    logic [7:0]  glyph_code;
    logic [2:0]  glyph_row;
    logic [5:0]  com_sel;
    gib_state_t  state;
    logic [2:0]  exec_cnt;
    logic [31:0] blink_cnt;
    logic        blink_phase;
    logic        aw_held;
    logic        w_held;
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;

    // ------------------------------------------------------------
    // blink masking shared by glyph rows and icons
    // ------------------------------------------------------------
    function automatic logic [5:0] blink_mask(input logic [7:0] b, input logic wide,
                                              input logic blink_on, input logic ph);
        logic [5:0] m;
        m = wide ? PAT6_MASK : PAT5_MASK;
        if (!blink_on || ph) begin
            blink_mask = m;
        end else if (b[BLINK_HI]) begin
            blink_mask = 6'h00;
        end else if (b[BLINK_LO]) begin
            blink_mask = wide ? (m & ~(6'h01 << PAT6_TOP)) : (m & ~(6'h01 << PAT5_TOP));
        end else begin
            blink_mask = m;
        end
    endfunction : blink_mask

    // ------------------------------------------------------------
    // instruction and register decode
    // ------------------------------------------------------------
    function automatic logic glyph_addr_cmd(input logic [7:0] c);
        glyph_addr_cmd = (c & 8'hC0) == CMD_SET_ADDR_GLYPH;
    endfunction : glyph_addr_cmd

    function automatic logic icon_addr_cmd(input logic [7:0] c);
        icon_addr_cmd = (c & 8'hF0) == CMD_SET_ADDR_ICON;
    endfunction : icon_addr_cmd

    function automatic logic host_port(input logic [ADDR_W-1:0] a);
        host_port = a == OFF_CMD || a == OFF_DATA;
    endfunction : host_port

    function automatic logic write_mapped(input logic [ADDR_W-1:0] a);
        write_mapped = a == OFF_CTRL || a == OFF_ICON_ROW || a == OFF_GLYPH_ROW || a == OFF_DISP_SEL;
    endfunction : write_mapped

    // ------------------------------------------------------------
    // axi write channel
    // ------------------------------------------------------------
    wire logic do_write = aw_held && w_held && !s_axi_bvalid_out;
    wire logic cmd_hit  = do_write && aw_addr == OFF_CMD && w_strb[0];
    wire logic dat_hit  = do_write && aw_addr == OFF_DATA && w_strb[0];
    wire logic rd_take  = s_axi_arvalid_in && !s_axi_rvalid_out;
    wire logic dat_read = rd_take && s_axi_araddr_in == OFF_DATA && !busy_flag_out;
    assign s_axi_awready_out = !aw_held;
    assign s_axi_wready_out  = !w_held;

    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_addr <= '0;
            w_data  <= '0;
            w_strb  <= '0;
        end else begin
            if (s_axi_awvalid_in && !aw_held) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr_in;
            end else if (do_write) begin
                aw_held <= 1'b0;
            end
            if (s_axi_wvalid_in && !w_held) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata_in;
                w_strb <= s_axi_wstrb_in;
            end else if (do_write) begin
                w_held <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            s_axi_bvalid_out <= 1'b0;
            s_axi_bresp_out  <= RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid_out <= 1'b1;
            s_axi_bresp_out  <= (write_mapped(aw_addr) || (host_port(aw_addr) && !busy_flag_out)) ? RESP_OKAY
                                                                                                : RESP_SLVERR;
        end else if (s_axi_bready_in) begin
            s_axi_bvalid_out <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ctrl       <= '0;
            icon_row   <= '0;
            glyph_code <= '0;
            glyph_row  <= '0;
            com_sel    <= '0;
        end else if (do_write && w_strb[0]) begin
            case (aw_addr)
                OFF_CTRL:      ctrl <= w_data[7:0];
                OFF_ICON_ROW:  icon_row <= w_data[3:0];
                OFF_GLYPH_ROW: begin
                    glyph_code <= w_data[7:0];
                    glyph_row  <= w_data[10:8];
                end
                OFF_DISP_SEL:  com_sel <= w_data[5:0];
                default:       ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // host latches and internal execution
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            instruction_latch <= '0;
            data_latch        <= '0;
            is_data           <= 1'b0;
            pend              <= 1'b0;
        end else if ((cmd_hit || dat_hit) && !busy_flag_out) begin
            pend <= 1'b1;
            is_data <= dat_hit;
            if (cmd_hit) begin
                instruction_latch <= w_data[7:0];
            end else begin
                data_latch <= w_data[7:0];
            end
        end else if (dat_read) begin
            pend    <= 1'b1;
            is_data <= 1'b0;
            instruction_latch <= '0;
        end else if (state == GIB_EXEC) begin
            pend <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // execution sequencer
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state    <= GIB_IDLE;
            exec_cnt <= '0;
        end else begin
            case (state)
                GIB_IDLE: begin
                    if (pend) begin
                        state    <= GIB_EXEC;
                        exec_cnt <= 3'(EXEC_CYC - 1);
                    end
                end
                GIB_EXEC: begin
                    if (exec_cnt == '0) begin
                        state <= GIB_IDLE;
                    end else begin
                        exec_cnt <= exec_cnt - 3'h1;
                    end
                end
                default: state <= GIB_IDLE;
            endcase
        end
    end

    assign busy_flag_out = pend || state == GIB_EXEC;

    // ------------------------------------------------------------
    // address counter and ram
    // ------------------------------------------------------------
    wire logic exec_now = state == GIB_EXEC && exec_cnt == 3'(EXEC_CYC - 1);
    wire logic [6:0] step_addr = ctrl[CTRL_INC] ? addr_ctr + 7'h01 : addr_ctr - 7'h01;

    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            addr_ctr    <= '0;
            target_icon <= 1'b0;
        end else if (exec_now && !is_data && instruction_latch != '0) begin
            if (ctrl[CTRL_IS]) begin
                if (glyph_addr_cmd(instruction_latch)) begin
                    addr_ctr    <= {1'b0, instruction_latch[5:0]};
                    target_icon <= 1'b0;
                end
            end else if (icon_addr_cmd(instruction_latch)) begin
                addr_ctr    <= {3'h0, instruction_latch[3:0]};
                target_icon <= 1'b1;
            end
        end else if (exec_now) begin
            addr_ctr <= step_addr;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (exec_now && is_data) begin
            if (target_icon) begin
                icon_ram[addr_ctr[3:0]] <= data_latch;
            end else begin
                user_glyph_ram[addr_ctr[5:0]] <= data_latch;
            end
        end
    end

    // ------------------------------------------------------------
    // read channel; busy on bit 7 only for instruction read
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            read_buf <= '0;
        end else if (dat_read) begin
            read_buf <= target_icon ? icon_ram[addr_ctr[3:0]] : user_glyph_ram[addr_ctr[5:0]];
        end
    end

    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            s_axi_rvalid_out <= 1'b0;
            s_axi_rdata_out  <= '0;
            s_axi_rresp_out  <= RESP_OKAY;
        end else if (rd_take) begin
            s_axi_rvalid_out <= 1'b1;
            s_axi_rresp_out  <= RESP_OKAY;
            case (s_axi_araddr_in)
                OFF_CTRL:   s_axi_rdata_out <= {24'h000000, ctrl};
                OFF_CMD:    s_axi_rdata_out <= {24'h000000, busy_flag_out, addr_ctr};
                OFF_DATA:   s_axi_rdata_out <= {24'h000000, read_buf};
                OFF_STATUS: s_axi_rdata_out <= {23'h000000, blink_phase, icon_active_out, 1'b0,
                                                segment_out};
                OFF_ICON_ROW:  s_axi_rdata_out <= {28'h0000000, icon_row};
                OFF_GLYPH_ROW: s_axi_rdata_out <= {21'h000000, glyph_row, glyph_code};
                OFF_DISP_SEL:  s_axi_rdata_out <= {26'h0000000, com_sel};
                default: begin
                    s_axi_rdata_out <= '0;
                    s_axi_rresp_out <= RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready_in) begin
            s_axi_rvalid_out <= 1'b0;
        end
    end
    assign s_axi_arready_out = !s_axi_rvalid_out;

    // ------------------------------------------------------------
    // blink timebase
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            blink_cnt   <= '0;
            blink_phase <= 1'b1;
        end else if (blink_cnt == 32'(BLINK_HALF - 1)) begin
            blink_cnt   <= '0;
            blink_phase <= ~blink_phase;
        end else begin
            blink_cnt <= blink_cnt + 32'h1;
        end
    end

    // ------------------------------------------------------------
    // segment output for the selected common
    // ------------------------------------------------------------
    wire logic [5:0] icon_pos = (ctrl[CTRL_LINES +: 2] == LINES_ONE) ? COM_POS_1L : COM_POS_24;
    wire logic icon_com = com_sel == COM_ICON || com_sel == icon_pos;
    wire logic [7:0] icon_byte = icon_ram[icon_row];
    wire logic [7:0] glyph_byte = user_glyph_ram[{glyph_code[2:0], glyph_row}];
    wire logic [7:0] src_byte = icon_com ? icon_byte : glyph_byte;
    wire logic [5:0] keep_mask = blink_mask(src_byte, ctrl[CTRL_WIDE], ctrl[CTRL_BLINK], blink_phase);

    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            segment_out     <= '0;
            icon_active_out <= 1'b0;
        end else begin
            icon_active_out <= icon_com && ctrl[CTRL_ICONS];
            segment_out <= (icon_com && !ctrl[CTRL_ICONS]) ? 6'h00 : src_byte[5:0] & keep_mask;
        end
    end
endmodule : gib_top
`default_nettype wire

// ===== tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb
    import gib_pkg::*;
;
    localparam int HALF = 8;
    typedef struct packed {logic [7:0] ctl, cmd, dat, sel; logic [5:0] on, off;} gib_case_t;
    localparam gib_case_t CASES [8] = '{
        '{8'h71, 8'h5A, 8'hFF, 8'h05, 6'h3F, 6'h3F}, '{8'h73, 8'h5A, 8'h3F, 8'h05, 6'h3F, 6'h3F},
        '{8'h73, 8'h5A, 8'h7F, 8'h05, 6'h3F, 6'h1F}, '{8'h73, 8'h5A, 8'hBF, 8'h05, 6'h3F, 6'h00},
        '{8'h72, 8'h5A, 8'h7F, 8'h05, 6'h1F, 6'h0F}, '{8'h72, 8'h5A, 8'hFF, 8'h05, 6'h1F, 6'h00},
        '{8'h63, 8'h85, 8'h6A, 8'h00, 6'h2A, 6'h0A}, '{8'h62, 8'h85, 8'hAA, 8'h00, 6'h0A, 6'h00}};
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0]  bresp, rresp;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, icon_act, busy;
    logic [5:0]  seg;
    int          n_fail = 0;
    int          n_compared = 0;
    always #50 clk = ~clk;
    gib_top #(.BLINK_HALF(HALF)) u_dut (.sys_clk_in(clk), .reset_n_in(rst_n),
        .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
        .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
        .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
        .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
        .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
        .segment_out(seg), .icon_active_out(icon_act), .busy_flag_out(busy));
    gib_host u_host (.clk_in(clk), .awaddr_out(awaddr), .awvalid_out(awvalid), .awready_in(awready),
        .wdata_out(wdata), .wvalid_out(wvalid), .wready_in(wready), .bresp_in(bresp), .bvalid_in(bvalid),
        .bready_out(bready), .araddr_out(araddr), .arvalid_out(arvalid), .arready_in(arready),
        .rdata_in(rdata), .rresp_in(rresp), .rvalid_in(rvalid), .rready_out(rready));
    task automatic stop_test();
        if (n_fail == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : stop_test
    task automatic hang();
        n_fail++;
        stop_test();
    endtask : hang
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic put(input logic [7:0] a, input logic [31:0] d, input logic [1:0] exp);
        logic [1:0] r;
        u_host.wr(a, d, r);
        chk({30'h0, r}, {30'h0, exp});
    endtask : put
    task automatic addr_is(input logic [7:0] exp);
        logic [31:0] d;
        logic [1:0]  r;
        u_host.wait_idle();
        u_host.rd(OFF_CMD, d, r);
        chk(d, {24'h0, exp});
    endtask : addr_is
    // segment shows both phases over two blink periods and nothing else
    task automatic watch(input logic [5:0] on, input logic [5:0] off);
        logic s_on, s_off, other;
        {s_on, s_off, other} = 3'h0;
        repeat (3) @(posedge clk);
        repeat (4 * HALF) begin
            @(posedge clk);
            if (seg === on) s_on = 1'b1;
            else if (seg === off) s_off = 1'b1;
            else other = 1'b1;
        end
        chk({29'h0, s_on, s_off | (on === off), other}, 32'h6);
    endtask : watch
    task automatic t_unmapped();
        logic [31:0] d;
        logic [1:0]  r;
        put(8'h1C, 32'hFF, RESP_SLVERR);
        u_host.rd(8'h1C, d, r);
        chk({30'h0, r}, {30'h0, RESP_SLVERR});
        chk(d, 32'h0);
    endtask : t_unmapped
    task automatic t_busy();
        logic [31:0] d;
        logic [1:0]  r;
        put(OFF_CTRL, 32'h73, RESP_OKAY);
        put(OFF_CMD, 32'h5A, RESP_OKAY);
        #1 chk({31'h0, busy}, 32'h1);
        put(OFF_DATA, 32'h11, RESP_SLVERR);
        addr_is(8'h1A);
        put(OFF_DATA, 32'h22, RESP_OKAY);
        u_host.rd(OFF_CMD, d, r);
        chk({31'h0, d[7]}, 32'h1);
        addr_is(8'h1B);
        put(OFF_CTRL, 32'h53, RESP_OKAY);
        put(OFF_DATA, 32'h33, RESP_OKAY);
        addr_is(8'h1A);
        u_host.rd(OFF_DATA, d, r);
        chk(d, 32'h0);
        addr_is(8'h19);
        u_host.rd(OFF_DATA, d, r);
        chk(d, 32'h22);
    endtask : t_busy
    task automatic t_blink();
        put(OFF_GLYPH_ROW, 32'h20B, RESP_OKAY);
        put(OFF_ICON_ROW, 32'h5, RESP_OKAY);
        foreach (CASES[i]) begin
            put(OFF_CTRL, 32'(CASES[i].ctl), RESP_OKAY);
            put(OFF_CMD, 32'(CASES[i].cmd), RESP_OKAY);
            u_host.wait_idle();
            put(OFF_DATA, 32'(CASES[i].dat), RESP_OKAY);
            u_host.wait_idle();
            put(OFF_DISP_SEL, 32'(CASES[i].sel), RESP_OKAY);
            watch(CASES[i].on, CASES[i].off);
        end
    endtask : t_blink
    task automatic t_common();
        logic [11:0] tab [7] = '{12'h100, 12'h111, 12'h005, 12'h521, 12'h411, 12'h900, 12'h200};
        foreach (tab[i]) begin
            put(OFF_CTRL, (32'h63 | {28'h0, tab[i][11:10], 2'h0}) & ~{25'h0, tab[i][9], 6'h0}, RESP_OKAY);
            put(OFF_DISP_SEL, {24'h0, tab[i][7:0]}, RESP_OKAY);
            repeat (3) @(posedge clk);
            chk({31'h0, icon_act}, {31'h0, tab[i][8]});
            if (tab[i][9]) chk({26'h0, seg}, 32'h0);
        end
    endtask : t_common
    initial begin
        repeat (2) @(posedge clk);
        chk({24'h0, busy, icon_act, seg}, 32'h0);
        rst_n <= 1'b1;
        t_unmapped();
        t_busy();
        t_blink();
        t_common();
        stop_test();
    end
endmodule : tb
`default_nettype wire
